// ==== shared/eqt_pkg.sv ====
// package for the extended query table slice: addresses, table bytes, carriers
package eqt_pkg;
	localparam int          ADDR_W        = 9;
	localparam int          DATA_W        = 16;
	localparam logic [8:0]  ADDR_FIRST    = 9'h117;
	localparam logic [8:0]  ADDR_LAST     = 9'h129;
	localparam logic [8:0]  ADDR_VPP      = 9'h117;
	localparam logic [8:0]  ADDR_OTP_CNT  = 9'h118;
	localparam logic [8:0]  ADDR_OTP1_0   = 9'h119;
	localparam logic [8:0]  ADDR_OTP1_1   = 9'h11A;
	localparam logic [8:0]  ADDR_OTP1_2   = 9'h11B;
	localparam logic [8:0]  ADDR_OTP1_3   = 9'h11C;
	localparam logic [8:0]  ADDR_PR2_0    = 9'h11D;
	localparam logic [8:0]  ADDR_PR2_1    = 9'h11E;
	localparam logic [8:0]  ADDR_PR2_2    = 9'h11F;
	localparam logic [8:0]  ADDR_PR2_3    = 9'h120;
	localparam logic [8:0]  ADDR_FGRP_LO  = 9'h121;
	localparam logic [8:0]  ADDR_FGRP_HI  = 9'h122;
	localparam logic [8:0]  ADDR_FGRP_EXP = 9'h123;
	localparam logic [8:0]  ADDR_UGRP_LO  = 9'h124;
	localparam logic [8:0]  ADDR_UGRP_HI  = 9'h125;
	localparam logic [8:0]  ADDR_UGRP_EXP = 9'h126;
	localparam logic [8:0]  ADDR_PAGE     = 9'h127;
	localparam logic [8:0]  ADDR_SYNC_CNT = 9'h128;
	localparam logic [8:0]  ADDR_SYNC1    = 9'h129;
	localparam logic [7:0]  VAL_VPP       = 8'h90;
	localparam logic [7:0]  VAL_OTP_CNT   = 8'h02;
	localparam logic [7:0]  VAL_OTP1_0    = 8'h80;
	localparam logic [7:0]  VAL_OTP1_1    = 8'h00;
	localparam logic [7:0]  VAL_OTP1_2    = 8'h03;
	localparam logic [7:0]  VAL_OTP1_3    = 8'h03;
	localparam logic [7:0]  VAL_PR2_0     = 8'h89;
	localparam logic [7:0]  VAL_ZERO      = 8'h00;
	localparam logic [7:0]  VAL_UGRP_LO   = 8'h10;
	localparam logic [7:0]  VAL_UGRP_EXP  = 8'h04;
	localparam logic [7:0]  VAL_PAGE      = 8'h05;
	localparam logic [7:0]  VAL_SYNC_CNT  = 8'h04;
	localparam logic [7:0]  VAL_SYNC1     = 8'h01;
	localparam logic [15:0] RESET_DATA    = 16'h0000;

	typedef struct packed {
		logic       valid;
		logic [8:0] addr;
	} eqt_req_t;

	typedef struct packed {
		logic        valid;
		logic        hit;
		logic [15:0] data;
	} eqt_rsp_t;
endpackage

// ==== verilog/eqt_lookup.sv ====
// combinational byte lookup for the query slice
`timescale 1ns/1ps
module eqt_lookup (
	input  wire logic [8:0] addr_in,
	output logic      [7:0] byte_out,
	output logic            hit_out
);
	always_comb begin
		hit_out  = 1'b1;
		byte_out = eqt_pkg::VAL_ZERO;
		unique case (addr_in)
			eqt_pkg::ADDR_VPP:      byte_out = eqt_pkg::VAL_VPP;
			eqt_pkg::ADDR_OTP_CNT:  byte_out = eqt_pkg::VAL_OTP_CNT;
			eqt_pkg::ADDR_OTP1_0:   byte_out = eqt_pkg::VAL_OTP1_0;
			eqt_pkg::ADDR_OTP1_1:   byte_out = eqt_pkg::VAL_OTP1_1;
			eqt_pkg::ADDR_OTP1_2:   byte_out = eqt_pkg::VAL_OTP1_2;
			eqt_pkg::ADDR_OTP1_3:   byte_out = eqt_pkg::VAL_OTP1_3;
			eqt_pkg::ADDR_PR2_0:    byte_out = eqt_pkg::VAL_PR2_0;
			eqt_pkg::ADDR_PR2_1,
			eqt_pkg::ADDR_PR2_2,
			eqt_pkg::ADDR_PR2_3:    byte_out = eqt_pkg::VAL_ZERO;
			eqt_pkg::ADDR_FGRP_LO,
			eqt_pkg::ADDR_FGRP_HI,
			eqt_pkg::ADDR_FGRP_EXP: byte_out = eqt_pkg::VAL_ZERO;
			eqt_pkg::ADDR_UGRP_LO:  byte_out = eqt_pkg::VAL_UGRP_LO;
			eqt_pkg::ADDR_UGRP_HI:  byte_out = eqt_pkg::VAL_ZERO;
			eqt_pkg::ADDR_UGRP_EXP: byte_out = eqt_pkg::VAL_UGRP_EXP;
			eqt_pkg::ADDR_PAGE:     byte_out = eqt_pkg::VAL_PAGE;
			eqt_pkg::ADDR_SYNC_CNT: byte_out = eqt_pkg::VAL_SYNC_CNT;
			eqt_pkg::ADDR_SYNC1:    byte_out = eqt_pkg::VAL_SYNC1;
			default: begin
				// addresses outside this slice belong to other parts of the query unit
				hit_out  = 1'b0;
				byte_out = eqt_pkg::VAL_ZERO;
			end
		endcase
	end
endmodule

// ==== verilog/eqt_query_slice.sv ====
// query-mode read slice for extended query bytes 117h..129h
// Notes on behaviour
// - address 117h returns 90h, program-supply voltage 9.0 volts.
// - address 118h returns 02h, two OTP fields; 00h would mean 256.
// - 119h..11Ch return 80h, 00h, 03h, 03h for the first OTP descriptor.
// - 11Dh..120h return 89h, 00h, 00h, 00h as the lock word address.
// - factory group count and size exponent at 121h..123h read 00h.
// - user group count 10h, 00h at 124h..125h; exponent 04h at 126h.
// - address 127h returns 05h, 32-byte read page.
// - address 128h returns 04h, four burst configuration fields follow.
// - address 129h returns 01h, four-word burst length.
`timescale 1ns/1ps
module eqt_query_slice (
	input  wire logic              mclk_in,
	input  wire logic              rstn_in,
	input  wire eqt_pkg::eqt_req_t req_in,
	output eqt_pkg::eqt_rsp_t      rsp_out
);
	logic [7:0]  lut_byte;
	logic        lut_hit;
	logic        resp_valid;
	logic        resp_hit;
	logic [15:0] resp_data;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// table answers always sit on the low lane, the upper lane reads zero
	function automatic logic [15:0] lane_word(input logic [7:0] tbl_byte);
		return {eqt_pkg::VAL_ZERO, tbl_byte};
	endfunction

	// addresses this slice owns; everything else belongs to the rest of the query unit
	function automatic logic in_slice(input logic [8:0] addr);
		return (addr >= eqt_pkg::ADDR_FIRST) && (addr <= eqt_pkg::ADDR_LAST);
	endfunction

	// ----------------------------------------------------------------
	// table lookup
	// ----------------------------------------------------------------
	eqt_lookup u_lookup (
		.addr_in  (req_in.addr),
		.byte_out (lut_byte),
		.hit_out  (lut_hit)
	);

	// ----------------------------------------------------------------
	// registered read data
	// ----------------------------------------------------------------
	// valid answers every taken request exactly one cycle later
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			resp_valid <= 1'b0;
		end else begin
			resp_valid <= req_in.valid;
		end
	end

	// hit tells the query unit whether this slice owns the address
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			resp_hit <= 1'b0;
		end else begin
			resp_hit <= req_in.valid & lut_hit;
		end
	end

	// one-cycle registered answer keeps the data lanes glitch free; data moves only on a request or under reset
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			resp_data <= eqt_pkg::RESET_DATA;
		end else if (req_in.valid) begin
			resp_data <= lane_word(lut_byte);
		end
	end

	assign rsp_out = {resp_valid, resp_hit, resp_data};

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_vpp;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_VPP |=> rsp_out.valid && rsp_out.data == 16'h0090;
	endproperty
	a_vpp: assert property (p_vpp) else $error("vpp byte wrong");

	property p_otp_cnt;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_OTP_CNT |=> rsp_out.data == 16'h0002;
	endproperty
	a_otp_cnt: assert property (p_otp_cnt) else $error("otp count wrong");

	property p_otp1;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_OTP1_0 |=> rsp_out.data == 16'h0080;
	endproperty
	a_otp1: assert property (p_otp1) else $error("otp descriptor wrong");

	property p_otp1_exp;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && (req_in.addr == eqt_pkg::ADDR_OTP1_2 || req_in.addr == eqt_pkg::ADDR_OTP1_3)
		|=> rsp_out.data == 16'h0003;
	endproperty
	a_otp1_exp: assert property (p_otp1_exp) else $error("otp exponent wrong");

	property p_pr2;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_PR2_0 |=> rsp_out.data == 16'h0089;
	endproperty
	a_pr2: assert property (p_pr2) else $error("lock word byte wrong");

	property p_fgrp;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr >= eqt_pkg::ADDR_FGRP_LO && req_in.addr <= eqt_pkg::ADDR_FGRP_EXP
		|=> rsp_out.data == 16'h0000 && rsp_out.hit;
	endproperty
	a_fgrp: assert property (p_fgrp) else $error("factory group not zero");

	property p_ugrp;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_UGRP_LO |=> rsp_out.data == 16'h0010;
	endproperty
	a_ugrp: assert property (p_ugrp) else $error("user group count wrong");

	property p_page;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_PAGE |=> rsp_out.data == 16'h0005;
	endproperty
	a_page: assert property (p_page) else $error("page capability wrong");

	property p_sync;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_SYNC_CNT ##1 req_in.valid
		&& req_in.addr == eqt_pkg::ADDR_SYNC1 |=> rsp_out.data == 16'h0001
		&& $past(rsp_out.data) == 16'h0004;
	endproperty
	a_sync: assert property (p_sync) else $error("burst field bytes wrong");

	property p_upper;
		@(posedge mclk_in) disable iff (!rstn_in)
		rsp_out.valid |-> rsp_out.data[15:8] == 8'h00;
	endproperty
	a_upper: assert property (p_upper) else $error("upper byte not zero");

	// ----------------------------------------------------------------
	// checks: remaining table bytes
	// ----------------------------------------------------------------
	property p_otp1_lock;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_OTP1_1 |=> rsp_out.data == 16'h0000 && rsp_out.hit;
	endproperty
	a_otp1_lock: assert property (p_otp1_lock) else $error("otp lock high byte wrong");

	property p_pr2_hi;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr >= eqt_pkg::ADDR_PR2_1 && req_in.addr <= eqt_pkg::ADDR_PR2_3
		|=> rsp_out.data == 16'h0000 && rsp_out.hit;
	endproperty
	a_pr2_hi: assert property (p_pr2_hi) else $error("lock word upper bytes wrong");

	property p_ugrp_hi;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_UGRP_HI |=> rsp_out.data == 16'h0000 && rsp_out.hit;
	endproperty
	a_ugrp_hi: assert property (p_ugrp_hi) else $error("user group high byte wrong");

	property p_ugrp_exp;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_UGRP_EXP |=> rsp_out.data == 16'h0004;
	endproperty
	a_ugrp_exp: assert property (p_ugrp_exp) else $error("user group exponent wrong");

	property p_sync_cnt;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_SYNC_CNT |=> rsp_out.data == 16'h0004;
	endproperty
	a_sync_cnt: assert property (p_sync_cnt) else $error("burst field count wrong");

	property p_sync1;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_SYNC1 |=> rsp_out.data == 16'h0001;
	endproperty
	a_sync1: assert property (p_sync1) else $error("first burst field wrong");

	property p_vpp_nibbles;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_VPP
		|=> rsp_out.data[7:4] == 4'h9 && rsp_out.data[3:0] == 4'h0 && rsp_out.hit;
	endproperty
	a_vpp_nibbles: assert property (p_vpp_nibbles) else $error("vpp nibbles wrong");

	property p_otp_cnt_hit;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_OTP_CNT |=> rsp_out.valid && rsp_out.hit;
	endproperty
	a_otp_cnt_hit: assert property (p_otp_cnt_hit) else $error("otp count not served");

	property p_page_hit;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && req_in.addr == eqt_pkg::ADDR_PAGE |=> rsp_out.valid && rsp_out.hit;
	endproperty
	a_page_hit: assert property (p_page_hit) else $error("page byte not served");

	// ----------------------------------------------------------------
	// checks: lanes and handshake
	// ----------------------------------------------------------------
	property p_hit;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && in_slice(req_in.addr) |=> rsp_out.valid && rsp_out.hit;
	endproperty
	a_hit: assert property (p_hit) else $error("slice address not claimed");

	property p_miss;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_in.valid && !in_slice(req_in.addr)
		|=> rsp_out.valid && !rsp_out.hit && rsp_out.data == 16'h0000;
	endproperty
	a_miss: assert property (p_miss) else $error("foreign address claimed");

	property p_idle;
		@(posedge mclk_in) disable iff (!rstn_in)
		!req_in.valid |=> !rsp_out.valid && !rsp_out.hit;
	endproperty
	a_idle: assert property (p_idle) else $error("answer without request");

	// the lanes must not move between reads or the host sees a spurious byte
	property p_hold;
		@(posedge mclk_in) disable iff (!rstn_in)
		!req_in.valid |=> $stable(rsp_out.data);
	endproperty
	a_hold: assert property (p_hold) else $error("data moved while idle");

	property p_reset;
		@(posedge mclk_in)
		!rstn_in |=> !rsp_out.valid && !rsp_out.hit && rsp_out.data == 16'h0000;
	endproperty
	a_reset: assert property (p_reset) else $error("answer not cleared by reset");
endmodule

// ==== verification/eqt_host_model.sv ====
// host model that issues query reads into the slice
`timescale 1ns/1ps
module eqt_host_model (
	input  wire logic         mclk_in,
	output eqt_pkg::eqt_req_t req_out
);
	initial req_out = '0;
	// -----------------------------------------------------------------
	// request driver
	// -----------------------------------------------------------------
	// one request per edge; an idle cycle shows the inverted last address, so a second idle in a row shows the stale one again
	task automatic drive(input logic v, input logic [8:0] a);
		@(posedge mclk_in) #1;
		if (v) begin
			req_out = {1'b1, a};
		end else begin
			req_out = {1'b0, ~req_out.addr};
		end
	endtask
endmodule

// ==== verification/tb_ext_query_table_rom.sv ====
// self-checking bench for the extended query table slice
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
	$display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_ext_query_table_rom;
	logic              mclk_in = 1'b0;
	logic              rstn_in = 1'b0;
	eqt_pkg::eqt_req_t req;
	eqt_pkg::eqt_rsp_t rsp;
	eqt_pkg::eqt_rsp_t pend = '0;
	int                err_count = 0;
	int                total_checks = 0;

	always #5 mclk_in = ~mclk_in;

	eqt_host_model host (.mclk_in(mclk_in), .req_out(req));
	eqt_query_slice dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .req_in(req), .rsp_out(rsp));

	// -----------------------------------------------------------------
	// transfer: issue this cycle's request, then check the answer to the previous one
	// -----------------------------------------------------------------
	task automatic x(input logic v, input logic [8:0] a, input logic [7:0] b, input logic h);
		host.drive(v, a);
		`CHK(rsp, pend)
		pend = v ? {1'b1, h, 8'h00, b} : {1'b0, 1'b0, pend.data};
	endtask

	task automatic t_table();
		x(1, 9'h117, 8'h90, 1);
		x(1, 9'h118, 8'h02, 1);
		x(1, 9'h119, 8'h80, 1);
		x(1, 9'h11A, 8'h00, 1);
		x(1, 9'h11B, 8'h03, 1);
		x(1, 9'h11C, 8'h03, 1);
		x(1, 9'h11D, 8'h89, 1);
		x(1, 9'h11E, 8'h00, 1);
		x(1, 9'h11F, 8'h00, 1);
		x(1, 9'h120, 8'h00, 1);
		x(1, 9'h121, 8'h00, 1);
		x(1, 9'h122, 8'h00, 1);
		x(1, 9'h123, 8'h00, 1);
		x(1, 9'h124, 8'h10, 1);
		x(1, 9'h125, 8'h00, 1);
		x(1, 9'h126, 8'h04, 1);
		x(1, 9'h127, 8'h05, 1);
		x(1, 9'h128, 8'h04, 1);
		x(1, 9'h129, 8'h01, 1);
		x(0, 9'h000, 8'h00, 0);
		$display("test table done");
	endtask

	// data holds the last byte while idle, valid and hit drop
	task automatic t_hold();
		x(1, 9'h127, 8'h05, 1);
		x(0, 9'h000, 8'h00, 0);
		x(0, 9'h000, 8'h00, 0);
		x(0, 9'h000, 8'h00, 0);
		$display("test hold done");
	endtask

	// neighbours just outside the slice must not alias into it
	task automatic t_miss();
		x(1, 9'h116, 8'h00, 0);
		x(1, 9'h12A, 8'h00, 0);
		x(1, 9'h017, 8'h00, 0);
		x(1, 9'h1FF, 8'h00, 0);
		x(1, 9'h128, 8'h04, 1);
		x(0, 9'h000, 8'h00, 0);
		$display("test miss done");
	endtask

	// reset in mid-stream drops requests seen under it; the first read after release is served
	task automatic t_reset();
		x(1, 9'h117, 8'h90, 1);
		rstn_in = 1'b0;
		pend = '0;
		x(1, 9'h118, 8'h02, 1);
		pend = '0;
		x(1, 9'h119, 8'h80, 1);
		rstn_in = 1'b1;
		x(0, 9'h000, 8'h00, 0);
		x(0, 9'h000, 8'h00, 0);
		$display("test reset done");
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge mclk_in);
		#1 rstn_in = 1'b1;
		t_table();
		t_hold();
		t_miss();
		t_reset();
		end_sim();
	end

	// whole run is well under a hundred cycles
	initial begin
		#5000;
		err_count++;
		end_sim();
	end
endmodule
